// ===== hdl/bst_tap.sv
`timescale 1ns/1ps
`include "bst_regs.svh"
module bst_tap
  import bst_pkg::*;
(
  // System clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_n_i,
  // Test port, tck domain
  input  wire logic                 tck_i,
  input  wire logic                 tms_i,
  input  wire logic                 tdi_i,
  input  wire logic                 trst_n_i,
  output logic                      tdo_o,
  output logic                      tdo_oe_o,
  // Core pins, ref_clk domain
  input  wire logic [`BST_NIN-1:0]  core_in_i,
  input  wire logic [`BST_NOUT-1:0] core_out_i,
  output logic      [`BST_NOUT-1:0] pin_out_o,
  output logic                      pin_oe_o,
  output logic                      test_mode_o
);
  import bst_pkg::*;

  localparam int CW = `BST_NIN + `BST_NOUT;

  // ****************************************
  // Resets and core-pin crossing into tck
  // ****************************************
  logic             arst_n;
  logic [CW-1:0]    pins_s1;
  logic [CW-1:0]    pins_s2;
  assign arst_n = trst_n_i & rst_n_i;

  always_ff @(posedge tck_i or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pins_s1 <= '0;
      pins_s2 <= '0;
    end
    else
    begin
      pins_s1 <= {core_out_i, core_in_i};
      pins_s2 <= pins_s1;
    end
  end

  // ****************************************
  // Controller
  // ****************************************
  bst_state_t state;
  bst_state_t next_state;

  always_comb
  begin
    unique case (state)
      BST_RESET:  next_state = tms_i ? BST_RESET : BST_IDLE;
      BST_IDLE:   next_state = tms_i ? BST_SELDR : BST_IDLE;
      BST_SELDR:  next_state = tms_i ? BST_SELIR : BST_CAPDR;
      BST_CAPDR:  next_state = tms_i ? BST_EX1DR : BST_SHDR;
      BST_SHDR:   next_state = tms_i ? BST_EX1DR : BST_SHDR;
      BST_EX1DR:  next_state = tms_i ? BST_UPDDR : BST_PAUSDR;
      BST_PAUSDR: next_state = tms_i ? BST_EX2DR : BST_PAUSDR;
      BST_EX2DR:  next_state = tms_i ? BST_UPDDR : BST_SHDR;
      BST_UPDDR:  next_state = tms_i ? BST_SELDR : BST_IDLE;
      BST_SELIR:  next_state = tms_i ? BST_RESET : BST_CAPIR;
      BST_CAPIR:  next_state = tms_i ? BST_EX1IR : BST_SHIR;
      BST_SHIR:   next_state = tms_i ? BST_EX1IR : BST_SHIR;
      BST_EX1IR:  next_state = tms_i ? BST_UPDIR : BST_PAUSIR;
      BST_PAUSIR: next_state = tms_i ? BST_EX2IR : BST_PAUSIR;
      BST_EX2IR:  next_state = tms_i ? BST_UPDIR : BST_SHIR;
      BST_UPDIR:  next_state = tms_i ? BST_SELDR : BST_IDLE;
      default:    next_state = BST_RESET;
    endcase
  end

  always_ff @(posedge tck_i or negedge arst_n)
  begin
    if (!arst_n)
      state <= BST_RESET;
    else
      state <= next_state;
  end

  // ****************************************
  // Instruction register
  // ****************************************
  logic [`BST_IR_W-1:0] ir_shift;
  logic [`BST_IR_W-1:0] ir;
  logic [`BST_IR_W-1:0] next_ir;

  always_ff @(posedge tck_i or negedge arst_n)
  begin
    if (!arst_n)
      ir_shift <= `BST_IR_CAPTURE;
    else if (state == BST_CAPIR)
      ir_shift <= `BST_IR_CAPTURE;
    else if (state == BST_SHIR)
      ir_shift <= {tdi_i, ir_shift[`BST_IR_W-1:1]};
  end

  always_comb
  begin
    if (state == BST_RESET)
      next_ir = `BST_OP_IDCODE;
    else if (state == BST_UPDIR)
      next_ir = ir_shift;
    else
      next_ir = ir;
  end

  always_ff @(posedge tck_i or negedge arst_n)
  begin
    if (!arst_n)
      ir <= `BST_OP_IDCODE;
    else
      ir <= next_ir;
  end

  logic sel_chain;
  logic sel_id;
  assign sel_chain   = (ir == `BST_OP_EXTEST) || (ir == `BST_OP_SAMPLE);
  assign sel_id      = (ir == `BST_OP_IDCODE);

  // ****************************************
  // Data registers
  // ****************************************
  logic                  single_bit_pass_reg;
  logic [`BST_ID_W-1:0]  identity_word_reg;
  logic [CW-1:0]         pin_cell_chain;
  logic [`BST_NOUT-1:0]  cell_hold;
  logic                  hold_tgl;
  logic [`BST_ID_W-1:0]  id_value;

  assign id_value = {`BST_ID_REV, `BST_ID_PART, `BST_ID_MFR, 1'b1};

  always_ff @(posedge tck_i or negedge arst_n)
  begin
    if (!arst_n)
      single_bit_pass_reg <= 1'b0;
    else if (state == BST_CAPDR)
      single_bit_pass_reg <= 1'b0;
    else if (state == BST_SHDR)
      single_bit_pass_reg <= tdi_i;
  end

  always_ff @(posedge tck_i or negedge arst_n)
  begin
    if (!arst_n)
      identity_word_reg <= '0;
    else if (sel_id && state == BST_CAPDR)
      identity_word_reg <= id_value;
    else if (sel_id && state == BST_SHDR)
      identity_word_reg <= {tdi_i, identity_word_reg[`BST_ID_W-1:1]};
  end

  always_ff @(posedge tck_i or negedge arst_n)
  begin
    if (!arst_n)
      pin_cell_chain <= '0;
    else if (sel_chain && state == BST_CAPDR)
      pin_cell_chain <= pins_s2;
    else if (sel_chain && state == BST_SHDR)
      pin_cell_chain <= {tdi_i, pin_cell_chain[CW-1:1]};
  end

  always_ff @(posedge tck_i or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cell_hold <= '0;
      hold_tgl  <= 1'b0;
    end
    else if (sel_chain && state == BST_UPDDR)
    begin
      cell_hold <= pin_cell_chain[CW-1:`BST_NIN];
      hold_tgl  <= ~hold_tgl;
    end
  end

  // ****************************************
  // Serial output on falling tck
  // ****************************************
  logic tdo_bit;
  always_comb
  begin
    if (state == BST_SHIR)
      tdo_bit = ir_shift[0];
    else if (sel_chain)
      tdo_bit = pin_cell_chain[0];
    else if (sel_id)
      tdo_bit = identity_word_reg[0];
    else
      tdo_bit = single_bit_pass_reg;
  end

  always_ff @(negedge tck_i or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end
    else
    begin
      tdo_o    <= tdo_bit;
      tdo_oe_o <= (state == BST_SHIR) || (state == BST_SHDR);
    end
  end

  // ****************************************
  // Pin control crossing into ref_clk
  // ****************************************
  logic                 drv_tck;
  logic                 hiz_tck;
  logic [1:0]           drv_s;
  logic [1:0]           hiz_s;
  logic [2:0]           tgl_s;
  logic [`BST_NOUT-1:0] hold_ref;

  // Follows the opcode taken at this edge, as tck may stop right after Update-IR
  always_ff @(posedge tck_i or negedge arst_n)
  begin
    if (!arst_n)
    begin
      drv_tck <= 1'b0;
      hiz_tck <= 1'b0;
    end
    else
    begin
      drv_tck <= (next_ir == `BST_OP_EXTEST) || (next_ir == `BST_OP_CLAMP);
      hiz_tck <= (next_ir == `BST_OP_HIGHZ);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      drv_s    <= '0;
      hiz_s    <= '0;
      tgl_s    <= '0;
      hold_ref <= '0;
    end
    else
    begin
      drv_s <= {drv_s[0], drv_tck};
      hiz_s <= {hiz_s[0], hiz_tck};
      tgl_s <= {tgl_s[1:0], hold_tgl};
      // Word taken only once its toggle has crossed, so every bit is settled
      if (tgl_s[2] != tgl_s[1])
        hold_ref <= cell_hold;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pin_out_o   <= '0;
      pin_oe_o    <= 1'b1;
      test_mode_o <= 1'b0;
    end
    else
    begin
      pin_out_o   <= drv_s[1] ? hold_ref : core_out_i;
      pin_oe_o    <= !hiz_s[1];
      test_mode_o <= drv_s[1] | hiz_s[1];
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_reset_idcode: assert property (@(posedge tck_i) disable iff (!arst_n)
    state == BST_RESET |=> ir == `BST_OP_IDCODE) else $error("reset did not select id");
  a_ir_update: assert property (@(posedge tck_i) disable iff (!arst_n)
    state == BST_UPDIR |=> ir == $past(ir_shift)) else $error("ir not updated");
  a_tms_reset: assert property (@(posedge tck_i) disable iff (!arst_n)
    tms_i [*5] |=> state == BST_RESET) else $error("five tms highs no reset");
  a_id_capture: assert property (@(posedge tck_i) disable iff (!arst_n)
    sel_id && state == BST_CAPDR |=> identity_word_reg[0] == 1'b1
      && identity_word_reg[`BST_ID_MFR_MSB:`BST_ID_MFR_LSB] == `BST_ID_MFR
      && identity_word_reg[`BST_ID_PART_MSB:`BST_ID_PART_LSB] == `BST_ID_PART
      && identity_word_reg[`BST_ID_REV_MSB:`BST_ID_REV_LSB] == `BST_ID_REV)
    else $error("bad id capture");
  a_bypass_path: assert property (@(posedge tck_i) disable iff (!arst_n)
    ir == `BST_OP_BYPASS && state == BST_SHDR ##1 state == BST_SHDR |-> ##0 tdo_bit == $past(tdi_i))
    else $error("bypass path wrong");
  a_chain_shift: assert property (@(posedge tck_i) disable iff (!arst_n)
    sel_chain && state == BST_SHDR |=> pin_cell_chain[CW-1] == $past(tdi_i)) else $error("chain no shift");
  a_chain_capture: assert property (@(posedge tck_i) disable iff (!arst_n)
    sel_chain && state == BST_CAPDR |=> pin_cell_chain == $past(pins_s2)) else $error("no sample");
  a_highz_pins: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    hiz_s[1] |=> !pin_oe_o) else $error("pins not tristated");
  a_drive_pins: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    drv_s[1] |=> pin_out_o == $past(hold_ref)) else $error("cells not driven");

  c_idcode: cover property (@(posedge tck_i) disable iff (!arst_n) sel_id && state == BST_SHDR);
  c_extest: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) drv_s[1]);
  c_highz: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) hiz_s[1]);
  c_ir_load: cover property (@(posedge tck_i) disable iff (!arst_n) state == BST_UPDIR);
endmodule

// ===== pkg/bst_pkg.sv
package bst_pkg;
  typedef enum logic [15:0] {
    BST_RESET  = 16'h0001, BST_IDLE   = 16'h0002, BST_SELDR  = 16'h0004, BST_CAPDR  = 16'h0008,
    BST_SHDR   = 16'h0010, BST_EX1DR  = 16'h0020, BST_PAUSDR = 16'h0040, BST_EX2DR  = 16'h0080,
    BST_UPDDR  = 16'h0100, BST_SELIR  = 16'h0200, BST_CAPIR  = 16'h0400, BST_SHIR   = 16'h0800,
    BST_EX1IR  = 16'h1000, BST_PAUSIR = 16'h2000, BST_EX2IR  = 16'h4000, BST_UPDIR  = 16'h8000
  } bst_state_t;
endpackage

// ===== pkg/bst_regs.svh
`ifndef BST_REGS_SVH
`define BST_REGS_SVH

// Instruction opcodes
`define BST_IR_W          4
`define BST_OP_EXTEST     4'h0
`define BST_OP_SAMPLE     4'h1
`define BST_OP_IDCODE     4'h2
`define BST_OP_CLAMP      4'h3
`define BST_OP_HIGHZ      4'h4
`define BST_OP_BYPASS     4'hf
`define BST_IR_CAPTURE    4'h1

// Identification word layout
`define BST_ID_W          32
`define BST_ID_REV_MSB    31
`define BST_ID_REV_LSB    28
`define BST_ID_PART_MSB   27
`define BST_ID_PART_LSB   12
`define BST_ID_MFR_MSB    11
`define BST_ID_MFR_LSB    1
`define BST_ID_MARK_BIT   0
// Arbitrary neutral identity values
`define BST_ID_REV        4'h5
`define BST_ID_PART       16'h1a2b
`define BST_ID_MFR        11'h2c4

// Boundary chain length: NIN inputs then NOUT output cells
`define BST_NIN           8
`define BST_NOUT          8

`endif

// ===== verif/bst_ctl_model.sv
`timescale 1ns/1ps
module bst_ctl_model
(
  // Test port toward the device
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  output logic      trst_n_o,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i
);
  // Rising edges seen with the serial output enabled during the last scan
  int oe_cnt = 0;

  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
    trst_n_o = 1'b1;
  end

  // One 6 ns test clock; tdo taken at the rising edge
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #3;
    tck_o = 1'b1;
    tdo = tdo_i;
    if (tdo_oe_i)
      oe_cnt++;
    #3;
    tck_o = 1'b0;
  endtask

  // Five ones reach reset, then park in idle
  task automatic go_reset();
    logic d;
    repeat (5) tick(1'b1, 1'b0, d);
    tick(1'b0, 1'b0, d);
  endtask

  task automatic trst_pulse();
    logic d;
    trst_n_o = 1'b0;
    #20;
    trst_n_o = 1'b1;
    #10;
    tick(1'b0, 1'b0, d);
  endtask

  // Idle to shift, n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic d;
    dout = '0;
    oe_cnt = 0;
    tick(1'b1, 1'b0, d);
    if (ir)
      tick(1'b1, 1'b0, d);
    tick(1'b0, 1'b0, d);
    tick(1'b0, 1'b0, d);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], d);
      dout[i] = d;
    end
    tick(1'b1, 1'b0, d);
    tick(1'b0, 1'b0, d);
    tdi_o = ~tdi_o;
  endtask
endmodule

// ===== verif/testbench.sv
`timescale 1ns/1ps
`include "bst_regs.svh"
module testbench;
  logic                 ref_clk_i = 1'b0;
  logic                 rst_n_i = 1'b0;
  logic                 tck, tms, tdi, trst_n, tdo_o, tdo_oe_o, pin_oe_o, test_mode_o;
  logic [`BST_NIN-1:0]  core_in_i = '0;
  logic [`BST_NOUT-1:0] core_out_i = '0;
  logic [`BST_NOUT-1:0] pin_out_o;
  logic [31:0]          rd;
  int                   error_cnt = 0;
  int                   check_count = 0;
  int                   cyc = 0;
  localparam logic [31:0] ID_EXP = {`BST_ID_REV, `BST_ID_PART, `BST_ID_MFR, 1'b1};

  always #5 ref_clk_i = ~ref_clk_i;

  bst_tap u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .trst_n_i(trst_n), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .core_in_i(core_in_i),
    .core_out_i(core_out_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .test_mode_o(test_mode_o));
  bst_ctl_model u_ctl (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n), .tdo_i(tdo_o),
    .tdo_oe_i(tdo_oe_o));

  // ****************
  // Checking
  // ****************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task conclude();
    $display("Mismatches %0d, comparisons %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task load_ir(input logic [3:0] op);
    u_ctl.scan(1'b1, 4, {28'h0, op}, rd);
    check(rd[3:0], `BST_IR_CAPTURE);
    check(u_ctl.oe_cnt, 32'h4);
    repeat (10) @(posedge ref_clk_i);
  endtask

  // ****************
  // Scenarios
  // ****************
  task test_idcode();
    u_ctl.go_reset();
    u_ctl.scan(1'b0, 32, 32'h0, rd);
    check(rd, ID_EXP);
    check(u_ctl.oe_cnt, 32'h20);
  endtask

  task test_sample_extest();
    @(posedge ref_clk_i);
    core_in_i <= 8'h3c;
    core_out_i <= 8'hc3;
    load_ir(`BST_OP_SAMPLE);
    u_ctl.scan(1'b0, 16, 32'h9600, rd);
    check(rd[15:0], 16'hc33c);
    check({test_mode_o, pin_oe_o, pin_out_o}, 10'h1c3);
    load_ir(`BST_OP_EXTEST);
    check({test_mode_o, pin_oe_o, pin_out_o}, 10'h396);
    u_ctl.scan(1'b0, 16, 32'h5a00, rd);
    check(rd[7:0], 8'h3c);
    repeat (10) @(posedge ref_clk_i);
    check(pin_out_o, 8'h5a);
  endtask

  task test_bypass_path();
    logic [3:0] ops [4];
    logic [9:0] pins [4];
    ops = '{`BST_OP_CLAMP, `BST_OP_HIGHZ, `BST_OP_BYPASS, `BST_OP_CLAMP};
    pins = '{10'h35a, 10'h200, 10'h1c3, 10'h35a};
    for (int i = 0; i < 4; i++)
    begin
      load_ir(ops[i]);
      u_ctl.scan(1'b0, 8, 32'ha5, rd);
      check(rd[7:0], 8'h4a);
      check({test_mode_o, pin_oe_o}, pins[i][9:8]);
      if (ops[i] != `BST_OP_HIGHZ)
        check(pin_out_o, pins[i][7:0]);
    end
  endtask

  task test_trst();
    u_ctl.trst_pulse();
    repeat (10) @(posedge ref_clk_i);
    check({test_mode_o, pin_oe_o, pin_out_o}, 10'h1c3);
    u_ctl.scan(1'b0, 32, 32'h0, rd);
    check(rd, ID_EXP);
  endtask

  always @(posedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt++;
      conclude();
    end
  end

  initial
  begin
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    test_idcode();
    test_sample_extest();
    test_bypass_path();
    test_trst();
    conclude();
  end
endmodule
